// [hw/lsti_core.sv]
// Purpose: threshold window interrupt with its configuration registers
// Assumes: bytes arrive already framed by the two-wire bus front end
// Notes:   interrupt pin is open drain, drives low only
//
// Behaviour
// - interrupt pin open drain, active low
// - level interrupt held until special clear command
// - halt bit stops integration on interrupt
// - mode field selects off or level output
// - mode code 11 forces interrupt asserted
// - persistence zero fires every conversion
// - persistence one fires on any out-of-window result
// - higher codes need that many out-of-window periods
// - only channel zero result is compared
// - result at or below low threshold is out
// - result above high threshold is out
// - thresholds are byte pairs, low byte first
// - threshold bytes reset to zero
// - first byte with top bit set sets pointer
// - gain field selects one of four gains
// - identification register is constant and read-only
// - control and analog registers reset to zero
`timescale 1ns/1ps
`default_nettype none

module lsti_core #(
    parameter logic [3:0] PART_ID = 4'h5, // arbitrary value
    parameter logic [3:0] REV_ID  = 4'h1  // arbitrary value
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        wr_valid_i,
    input  wire logic        wr_first_i,
    input  wire logic [7:0]  wr_byte_i,
    input  wire logic        rd_req_i,
    output logic [7:0]       rd_data_o,
    output logic             rd_valid_o,
    input  wire logic        conv_done_i,
    input  wire logic [15:0] ch0_result_i,
    input  wire logic        irq_pin_i,
    output logic             irq_pin_o,
    output logic             irq_pin_oe_o,
    output logic             irq_line_sense_o,
    output logic             integ_halt_o,
    output logic [1:0]       gain_sel_o
);

    // register state
    logic [7:0]  irq_ctrl_ff;
    logic [15:0] low_thr_ff;
    logic [15:0] high_thr_ff;
    logic [1:0]  gain_ff;
    logic [4:0]  ptr_ff;
    logic [4:0]  nxt_ptr;
    logic        irq_flag_ff;
    logic        nxt_irq_flag;
    logic [7:0]  rd_data_ff;
    logic        rd_valid_ff;
    logic        pin_sync1_ff;
    logic        pin_sync2_ff;

    // byte decode
    logic        is_cmd;
    logic        is_data;
    logic        clear_cmd;
    logic        wr_ctrl;
    logic        wr_low_lsb;
    logic        wr_low_msb;
    logic        wr_high_lsb;
    logic        wr_high_msb;
    logic        wr_analog;
    logic [7:0]  rd_mux;

    // interrupt decode
    logic [1:0]  mode;
    logic [3:0]  pers;
    logic        halt_en;
    logic        mode_level;
    logic        mode_test;
    logic        below_low;
    logic        above_high;
    logic        out_of_range;
    logic        fire;
    logic        irq_act;
    logic [3:0]  pers_count;

    // a first byte with its top bit set is a command, never data
    assign is_cmd    = wr_valid_i & wr_first_i & wr_byte_i[lsti_pkg::CMD_FLAG_BIT];
    assign is_data   = wr_valid_i & !is_cmd;
    assign clear_cmd = is_cmd & (wr_byte_i[lsti_pkg::TRANS_HI:lsti_pkg::TRANS_LO]
                                 == lsti_pkg::TRANS_SPECIAL);

    assign wr_ctrl     = is_data & (ptr_ff == lsti_pkg::ADDR_IRQ_CTRL);
    assign wr_low_lsb  = is_data & (ptr_ff == lsti_pkg::ADDR_LOW_LSB);
    assign wr_low_msb  = is_data & (ptr_ff == lsti_pkg::ADDR_LOW_MSB);
    assign wr_high_lsb = is_data & (ptr_ff == lsti_pkg::ADDR_HIGH_LSB);
    assign wr_high_msb = is_data & (ptr_ff == lsti_pkg::ADDR_HIGH_MSB);
    assign wr_analog   = is_data & (ptr_ff == lsti_pkg::ADDR_ANALOG);

    // pointer loads on command, steps after each data byte or read
    assign nxt_ptr = is_cmd ? wr_byte_i[lsti_pkg::CMD_ADDR_HI:0]
                   : (is_data | rd_req_i) ? ptr_ff + lsti_pkg::PTR_STEP
                   : ptr_ff;

    // read selection, reserved bits and unmapped pointers read zero
    assign rd_mux =
        (ptr_ff == lsti_pkg::ADDR_IRQ_CTRL) ? irq_ctrl_ff :
        (ptr_ff == lsti_pkg::ADDR_LOW_LSB)  ? low_thr_ff[7:0] :
        (ptr_ff == lsti_pkg::ADDR_LOW_MSB)  ? low_thr_ff[15:8] :
        (ptr_ff == lsti_pkg::ADDR_HIGH_LSB) ? high_thr_ff[7:0] :
        (ptr_ff == lsti_pkg::ADDR_HIGH_MSB) ? high_thr_ff[15:8] :
        (ptr_ff == lsti_pkg::ADDR_ANALOG)   ? {6'h00, gain_ff} :
        (ptr_ff == lsti_pkg::ADDR_ID)       ? {PART_ID, REV_ID} :
        lsti_pkg::READ_FILL;

    // control fields
    assign mode       = irq_ctrl_ff[lsti_pkg::MODE_HI:lsti_pkg::MODE_LO];
    assign pers       = irq_ctrl_ff[lsti_pkg::PERS_HI:lsti_pkg::PERS_LO];
    assign halt_en    = irq_ctrl_ff[lsti_pkg::HALT_BIT];
    assign mode_level = (mode == lsti_pkg::MODE_LEVEL);
    assign mode_test  = (mode == lsti_pkg::MODE_TEST);

    // window compare on channel zero only
    assign below_low    = ch0_result_i <= low_thr_ff;
    assign above_high   = ch0_result_i > high_thr_ff;
    assign out_of_range = below_low | above_high;

    lsti_persist #(
        .W              (lsti_pkg::PERS_W)
    ) u_persist (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .sample_i       (conv_done_i & mode_level),
        .out_of_range_i (out_of_range),
        .clear_i        (clear_cmd),
        .pers_i         (pers),
        .fire_o         (fire),
        .count_o        (pers_count)
    );

    // sticky level flag, a new event beats a clear in the same cycle
    assign nxt_irq_flag = fire ? 1'b1 : clear_cmd ? 1'b0 : irq_flag_ff;

    // off and reserved codes keep the pin released
    assign irq_act = (mode_level & irq_flag_ff) | mode_test;

    // open drain: only ever drive low
    assign irq_pin_o    = 1'b0;
    assign irq_pin_oe_o = irq_act;

    // integration stays halted while the interrupt pin is driven and the halt bit is set
    assign integ_halt_o = halt_en & irq_act;

    assign gain_sel_o       = gain_ff;
    assign rd_data_o        = rd_data_ff;
    assign rd_valid_o       = rd_valid_ff;
    assign irq_line_sense_o = pin_sync2_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ctrl_ff <= lsti_pkg::REG_RESET;
            gain_ff     <= lsti_pkg::REG_RESET[1:0];
        end else begin
            if (wr_ctrl) begin
                irq_ctrl_ff <= {1'b0, wr_byte_i[6:0]};
            end
            if (wr_analog) begin
                gain_ff <= wr_byte_i[lsti_pkg::GAIN_HI:lsti_pkg::GAIN_LO];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            low_thr_ff  <= lsti_pkg::THR_RESET;
            high_thr_ff <= lsti_pkg::THR_RESET;
        end else begin
            if (wr_low_lsb) begin
                low_thr_ff[7:0] <= wr_byte_i;
            end
            if (wr_low_msb) begin
                low_thr_ff[15:8] <= wr_byte_i;
            end
            if (wr_high_lsb) begin
                high_thr_ff[7:0] <= wr_byte_i;
            end
            if (wr_high_msb) begin
                high_thr_ff[15:8] <= wr_byte_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_ff      <= lsti_pkg::ADDR_IRQ_CTRL;
            irq_flag_ff <= 1'b0;
            rd_data_ff  <= lsti_pkg::READ_FILL;
            rd_valid_ff <= 1'b0;
        end else begin
            ptr_ff      <= nxt_ptr;
            irq_flag_ff <= nxt_irq_flag;
            rd_data_ff  <= rd_req_i ? rd_mux : rd_data_ff;
            rd_valid_ff <= rd_req_i;
        end
    end

    // pin level sense through two flops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_sync1_ff <= 1'b1;
            pin_sync2_ff <= 1'b1;
        end else begin
            pin_sync1_ff <= irq_pin_i;
            pin_sync2_ff <= pin_sync1_ff;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_clear_only;
        clear_cmd && !fire;
    endsequence

    sequence s_released_level;
        !irq_flag_ff && !irq_pin_oe_o;
    endsequence

    sequence s_level_armed;
        mode_level && irq_flag_ff;
    endsequence

    sequence s_low_pair;
        wr_low_lsb ##1 wr_low_msb;
    endsequence

    sequence s_high_pair;
        wr_high_lsb ##1 wr_high_msb;
    endsequence

    chk_open_drain_low: assert property (
        irq_pin_o == 1'b0)
        else $error("interrupt pin driven high");
    chk_level_hold: assert property (
        (s_level_armed ##0 (!clear_cmd && !wr_ctrl && mode_level)) |=> (irq_flag_ff && irq_pin_oe_o))
        else $error("level interrupt dropped without clear");
    chk_clear_release: assert property (
        (s_clear_only ##0 (mode_level && !mode_test)) ##1 !fire |-> s_released_level)
        else $error("interrupt not released by clear command");
    chk_halt_follow: assert property (
        integ_halt_o == (irq_pin_oe_o && irq_ctrl_ff[lsti_pkg::HALT_BIT]))
        else $error("integration halt does not follow interrupt");
    chk_mode_off: assert property (
        (mode == lsti_pkg::MODE_OFF) |-> !irq_pin_oe_o)
        else $error("interrupt driven while disabled");
    chk_test_forced: assert property (
        ((wr_ctrl && wr_byte_i[5:4] == 2'h3) ##1 !wr_ctrl) |-> irq_pin_oe_o [*2])
        else $error("test mode did not force interrupt");
    chk_every_conv: assert property (
        (conv_done_i && mode_level && pers == lsti_pkg::PERS_EVERY) |=> irq_flag_ff)
        else $error("persistence zero conversion did not interrupt");
    chk_single_out: assert property (
        (conv_done_i && mode_level && pers == lsti_pkg::PERS_SINGLE && out_of_range)
        |=> irq_flag_ff)
        else $error("single out-of-window result did not interrupt");
    chk_low_equal: assert property (
        (conv_done_i && mode_level && pers == lsti_pkg::PERS_SINGLE
         && !wr_ctrl && ch0_result_i == low_thr_ff) |=> irq_pin_oe_o)
        else $error("result equal to low threshold not out of range");
    chk_high_equal: assert property (
        (conv_done_i && mode_level && pers == lsti_pkg::PERS_SINGLE && !irq_flag_ff
         && !clear_cmd && ch0_result_i == high_thr_ff && ch0_result_i > low_thr_ff)
        |=> !irq_flag_ff)
        else $error("result equal to high threshold counted out of range");
    chk_word_write: assert property (
        s_low_pair |=> low_thr_ff == {$past(wr_byte_i), $past(wr_byte_i, 2)})
        else $error("low threshold word write not assembled");
    chk_cmd_pointer: assert property (
        is_cmd |=> (ptr_ff == $past(wr_byte_i[4:0])) && $stable(low_thr_ff)
                   && $stable(irq_ctrl_ff))
        else $error("command byte not taken as pointer");
    chk_gain_write: assert property (
        wr_analog |=> gain_sel_o == $past(wr_byte_i[1:0]))
        else $error("gain select not updated");
    chk_id_read: assert property (
        (rd_req_i && ptr_ff == lsti_pkg::ADDR_ID) |=> rd_valid_o && rd_data_o == {PART_ID, REV_ID})
        else $error("identification read wrong");
    chk_reset_values: assert property (
        disable iff (1'b0)
        $fell(rst_i) |-> (irq_ctrl_ff == 8'h00 && gain_ff == 2'h0 && low_thr_ff == 16'h0000
                          && high_thr_ff == 16'h0000 && !irq_pin_oe_o))
        else $error("registers not zero after reset");

    // flag, mode and halt checks
    chk_set_wins: assert property (
        (fire && clear_cmd) |=> irq_flag_ff)
        else $error("clear beat a same-cycle interrupt event");
    chk_flag_clear: assert property (
        (clear_cmd && !fire) |=> !irq_flag_ff)
        else $error("interrupt flag not cleared by clear command");
    chk_clear_count: assert property (
        clear_cmd |=> (pers_count == 4'h0))
        else $error("persistence count not cleared by clear command");
    chk_flag_level_only: assert property (
        (!mode_level && !irq_flag_ff) |=> !irq_flag_ff)
        else $error("interrupt flag set outside level mode");
    chk_mode_reserved: assert property (
        (!mode_level && !mode_test) |-> !irq_pin_oe_o)
        else $error("interrupt driven in off or reserved mode");
    chk_test_hold: assert property (
        mode_test |-> irq_pin_oe_o)
        else $error("test mode released the interrupt");
    chk_off_no_halt: assert property (
        (mode == lsti_pkg::MODE_OFF) |-> !integ_halt_o)
        else $error("integration halted while interrupt disabled");
    chk_halt_needs_bit: assert property (
        !halt_en |-> !integ_halt_o)
        else $error("integration halted without halt bit");
    chk_ctrl_reserved: assert property (
        !irq_ctrl_ff[7])
        else $error("reserved control bit stored");

    // register port checks
    chk_ptr_step: assert property (
        (is_data || rd_req_i) |=> ptr_ff == $past(ptr_ff) + lsti_pkg::PTR_STEP)
        else $error("pointer did not step after data or read");
    chk_high_word: assert property (
        s_high_pair |=> high_thr_ff == {$past(wr_byte_i), $past(wr_byte_i, 2)})
        else $error("high threshold word write not assembled");
    chk_gain_hold: assert property (
        !wr_analog |=> $stable(gain_sel_o))
        else $error("gain select changed without write");
    chk_read_valid: assert property (
        rd_req_i |=> rd_valid_o)
        else $error("read valid missing after read request");
    chk_read_idle: assert property (
        !rd_req_i |=> (!rd_valid_o && $stable(rd_data_o)))
        else $error("read data or valid changed without request");

endmodule

`default_nettype wire

// [hw/lsti_pkg.sv]
// Purpose: shared constants of the light sensor threshold interrupt block
// Assumes: byte-wide register file behind a command-pointer byte interface
// Notes:   definitions only
`default_nettype none

package lsti_pkg;

    // register pointer values
    localparam int          PTR_W          = 5;
    localparam logic [4:0]  ADDR_IRQ_CTRL  = 5'h02;
    localparam logic [4:0]  ADDR_LOW_LSB   = 5'h03;
    localparam logic [4:0]  ADDR_LOW_MSB   = 5'h04;
    localparam logic [4:0]  ADDR_HIGH_LSB  = 5'h05;
    localparam logic [4:0]  ADDR_HIGH_MSB  = 5'h06;
    localparam logic [4:0]  ADDR_ANALOG    = 5'h07;
    localparam logic [4:0]  ADDR_ID        = 5'h12;
    localparam logic [4:0]  PTR_STEP       = 5'h01;

    // command byte layout
    localparam int          CMD_FLAG_BIT   = 7;
    localparam int          TRANS_HI       = 6;
    localparam int          TRANS_LO       = 5;
    localparam int          CMD_ADDR_HI    = 4;
    localparam logic [1:0]  TRANS_SPECIAL  = 2'h3;

    // irq control layout
    localparam int          HALT_BIT       = 6;
    localparam int          MODE_HI        = 5;
    localparam int          MODE_LO        = 4;
    localparam int          PERS_HI        = 3;
    localparam int          PERS_LO        = 0;
    localparam int          PERS_W         = 4;
    localparam logic [1:0]  MODE_OFF       = 2'h0;
    localparam logic [1:0]  MODE_LEVEL     = 2'h1;
    localparam logic [1:0]  MODE_TEST      = 2'h3;
    localparam logic [3:0]  PERS_EVERY     = 4'h0;
    localparam logic [3:0]  PERS_SINGLE    = 4'h1;

    // analog gain layout
    localparam int          GAIN_HI        = 1;
    localparam int          GAIN_LO        = 0;

    // identification layout
    localparam int          ID_FIELD_W     = 4;

    // reset and fill values
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  READ_FILL      = 8'h00;
    localparam logic [15:0] THR_RESET      = 16'h0000;

endpackage

`default_nettype wire

// [hw/lsti_persist.sv]
// Purpose: persistence filter counting out-of-window conversions
// Assumes: sample_i is a one-cycle pulse per finished conversion
// Notes:   counter saturates at its top value
`timescale 1ns/1ps
`default_nettype none

module lsti_persist #(
    parameter int W = 4
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    input  wire logic          sample_i,
    input  wire logic          out_of_range_i,
    input  wire logic          clear_i,
    input  wire logic [W-1:0]  pers_i,
    output logic               fire_o,
    output logic [W-1:0]       count_o
);

    localparam logic [W-1:0] CNT_ZERO = '0;
    localparam logic [W-1:0] CNT_TOP  = '1;
    localparam logic [W:0]   CNT_ONE  = {{W{1'b0}}, 1'b1};

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic [W:0]   cnt_plus;
    logic         reached;

    assign cnt_plus = {1'b0, cnt_ff} + CNT_ONE;
    assign reached  = cnt_plus >= {1'b0, pers_i};
    // zero code fires on every sample, otherwise count of out-of-window results
    assign fire_o   = sample_i & ((pers_i == CNT_ZERO) | (out_of_range_i & reached));
    assign count_o  = cnt_ff;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (clear_i) begin
            nxt_cnt = CNT_ZERO;
        end else if (sample_i & !out_of_range_i) begin
            nxt_cnt = CNT_ZERO;
        end else if (sample_i & (cnt_ff != CNT_TOP)) begin
            nxt_cnt = cnt_plus[W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= CNT_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_persist_reach: assert property (
        (sample_i && out_of_range_i && pers_i > 4'h1 && cnt_plus == {1'b0, pers_i}) |-> fire_o)
        else $error("persistence count reached but no interrupt");
    chk_persist_early: assert property (
        (sample_i && pers_i > 4'h1 && cnt_plus < {1'b0, pers_i}) |-> !fire_o)
        else $error("interrupt before persistence count reached");
    chk_inrange_reset: assert property (
        (sample_i && !out_of_range_i) |=> (cnt_ff == CNT_ZERO))
        else $error("persistence count not reset by in-window result");

endmodule

`default_nettype wire

// [verification/lsti_irq_line.sv]
// Purpose: far side of the interrupt pin, a pulled-up shared line
// Assumes: device only ever pulls the line low
// Notes:   line reads high whenever nobody drives it
`timescale 1ns/1ps
`default_nettype none

module lsti_irq_line (
    input  wire logic drv_oe_i,
    input  wire logic drv_i,
    output logic      line_o
);
    // pull-up wins while the driver is released
    assign line_o = drv_oe_i ? drv_i : 1'b1;
endmodule

`default_nettype wire

// [verification/test_lsti_core.sv]
// Purpose: self-checking bench of the threshold interrupt core
// Assumes: byte port framing per hand-over, pulled-up interrupt line
// Notes:   random thresholds and results from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none

module test_lsti_core;
    localparam logic [3:0] PART_V = 4'hA; // arbitrary value
    localparam logic [3:0] REV_V  = 4'h3; // arbitrary value
    logic        clk_sys_i;
    logic        rst_i;
    logic        wr_valid_i;
    logic        wr_first_i;
    logic [7:0]  wr_byte_i;
    logic        rd_req_i;
    logic [7:0]  rd_data_o;
    logic        rd_valid_o;
    logic        conv_done_i;
    logic [15:0] ch0_result_i;
    logic        irq_pin_o;
    logic        irq_pin_oe_o;
    logic        irq_line_sense_o;
    logic        integ_halt_o;
    logic [1:0]  gain_sel_o;
    wire         irq_line;
    int          bad_count;
    int          num_checks;
    int          n;
    logic [31:0] seed;
    logic [15:0] lo_v;
    logic [15:0] hi_v;
    logic [15:0] r;
    logic [7:0]  gv;

    lsti_core #(.PART_ID(PART_V), .REV_ID(REV_V)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_valid_i(wr_valid_i),
        .wr_first_i(wr_first_i), .wr_byte_i(wr_byte_i), .rd_req_i(rd_req_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .conv_done_i(conv_done_i),
        .ch0_result_i(ch0_result_i), .irq_pin_i(irq_line), .irq_pin_o(irq_pin_o),
        .irq_pin_oe_o(irq_pin_oe_o), .irq_line_sense_o(irq_line_sense_o),
        .integ_halt_o(integ_halt_o), .gain_sel_o(gain_sel_o)
    );
    lsti_irq_line line_m (.drv_oe_i(irq_pin_oe_o), .drv_i(irq_pin_o), .line_o(irq_line));

    function automatic void nr();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction
    function automatic logic is_out(input logic [15:0] v);
        return (v <= lo_v) || (v > hi_v);
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wb(input logic f, input logic [7:0] b);
        @(negedge clk_sys_i);
        wr_valid_i = 1'b1;
        wr_first_i = f;
        wr_byte_i  = b;
        @(negedge clk_sys_i);
        wr_valid_i = 1'b0;
        wr_first_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp);
        @(negedge clk_sys_i);
        rd_req_i = 1'b1;
        @(negedge clk_sys_i);
        rd_req_i = 1'b0;
        chk("rd_valid", {15'h0, rd_valid_o}, 16'h0001);
        chk("rd_data", {8'h0, rd_data_o}, {8'h0, exp});
    endtask
    task automatic setw(input logic [4:0] a, input logic [7:0] v);
        wb(1'b1, {3'b100, a});
        wb(1'b0, v);
    endtask
    task automatic word(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk_sys_i);
        wr_valid_i = 1'b1;
        wr_first_i = 1'b1;
        wr_byte_i  = {3'b100, a};
        @(negedge clk_sys_i);
        wr_first_i = 1'b0;
        wr_byte_i  = v[7:0];
        @(negedge clk_sys_i);
        wr_byte_i  = v[15:8];
        @(negedge clk_sys_i);
        wr_valid_i = 1'b0;
    endtask
    task automatic clr();
        wb(1'b1, {3'b111, lsti_pkg::ADDR_IRQ_CTRL});
        chk("irq_oe_clr", {15'h0, irq_pin_oe_o}, 16'h0000);
    endtask
    task automatic conv(input logic [15:0] v, input logic exp);
        @(negedge clk_sys_i);
        conv_done_i  = 1'b1;
        ch0_result_i = v;
        @(negedge clk_sys_i);
        conv_done_i  = 1'b0;
        ch0_result_i = ~v;
        chk("irq_oe", {15'h0, irq_pin_oe_o}, {15'h0, exp});
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        bad_count++;
        print_verdict();
    end
    initial begin
        rst_i        = 1'b1;
        wr_valid_i   = 1'b0;
        wr_first_i   = 1'b0;
        wr_byte_i    = 8'h00;
        rd_req_i     = 1'b0;
        conv_done_i  = 1'b0;
        ch0_result_i = 16'h0000;
        bad_count    = 0;
        num_checks   = 0;
        seed         = 32'h15b0_a8cd;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk("irq_oe_rst", {15'h0, irq_pin_oe_o}, 16'h0000);
        chk("gain_rst", {14'h0, gain_sel_o}, 16'h0000);
        wb(1'b1, 8'h82);
        for (int i = 0; i < 6; i++) rd(8'h00);
        wb(1'b1, 8'h92);
        rd({PART_V, REV_V});
        setw(lsti_pkg::ADDR_ID, ~{PART_V, REV_V});
        wb(1'b1, 8'h92);
        rd({PART_V, REV_V});
        for (int g = 0; g < 4; g++) begin
            gv = 8'(g);
            setw(lsti_pkg::ADDR_ANALOG, gv);
            chk("gain_sel", {14'h0, gain_sel_o}, {8'h0, gv});
            wb(1'b1, 8'h87);
            rd(gv);
        end
        nr();
        lo_v = {2'b00, seed[13:0]};
        nr();
        hi_v = lo_v + 16'h1000 + {4'h0, seed[11:0]};
        word(lsti_pkg::ADDR_LOW_LSB, lo_v);
        word(lsti_pkg::ADDR_HIGH_LSB, hi_v);
        wb(1'b1, 8'h83);
        rd(lo_v[7:0]);
        rd(lo_v[15:8]);
        rd(hi_v[7:0]);
        rd(hi_v[15:8]);
        wb(1'b1, 8'h85);
        wb(1'b1, 8'h85);
        rd(hi_v[7:0]);
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h11);
        conv(lo_v + 16'h0001, 1'b0);
        conv(hi_v, 1'b0);
        conv(lo_v, 1'b1);
        conv(lo_v + 16'h0001, 1'b1);
        clr();
        conv(hi_v + 16'h0001, 1'b1);
        clr();
        @(negedge clk_sys_i);
        conv_done_i  = 1'b1;
        ch0_result_i = lo_v;
        wr_valid_i   = 1'b1;
        wr_first_i   = 1'b1;
        wr_byte_i    = {3'b111, lsti_pkg::ADDR_IRQ_CTRL};
        @(negedge clk_sys_i);
        conv_done_i  = 1'b0;
        wr_valid_i   = 1'b0;
        wr_first_i   = 1'b0;
        chk("irq_set_wins", {15'h0, irq_pin_oe_o}, 16'h0001);
        clr();
        for (int k = 0; k < 24; k++) begin
            nr();
            r = lo_v + {3'h0, seed[12:0]} - 16'h0400;
            conv(r, is_out(r));
            clr();
        end
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h10);
        conv(lo_v + 16'h0001, 1'b1);
        clr();
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h51);
        chk("halt_idle", {15'h0, integ_halt_o}, 16'h0000);
        conv(lo_v, 1'b1);
        chk("halt_on", {15'h0, integ_halt_o}, 16'h0001);
        clr();
        chk("halt_off", {15'h0, integ_halt_o}, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            nr();
            n = (k == 0) ? 2 : (k == 1) ? 15 : 2 + int'(seed[7:0] % 14);
            setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h10 | 8'(n));
            for (int i = 1; i < n; i++) conv(lo_v >> (i % 3), 1'b0);
            conv(lo_v + 16'h0001, 1'b0);
            for (int i = 1; i <= n; i++) conv(hi_v + 16'(i), 1'(i == n));
            clr();
            for (int i = 1; i < n; i++) conv(lo_v, 1'b0);
            clr();
        end
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h01);
        conv(lo_v, 1'b0);
        conv(hi_v + 16'h0001, 1'b0);
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h21);
        conv(lo_v, 1'b0);
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h30);
        chk("irq_oe_test", {15'h0, irq_pin_oe_o}, 16'h0001);
        repeat (3) @(negedge clk_sys_i);
        chk("line_low", {15'h0, irq_line_sense_o}, 16'h0000);
        chk("pin_level", {15'h0, irq_pin_o}, 16'h0000);
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h00);
        chk("irq_oe_off", {15'h0, irq_pin_oe_o}, 16'h0000);
        repeat (3) @(negedge clk_sys_i);
        chk("line_high", {15'h0, irq_line_sense_o}, 16'h0001);
        setw(lsti_pkg::ADDR_ANALOG, 8'h03);
        setw(lsti_pkg::ADDR_IRQ_CTRL, 8'h30);
        chk("irq_oe_pre", {15'h0, irq_pin_oe_o}, 16'h0001);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk("irq_oe_rst2", {15'h0, irq_pin_oe_o}, 16'h0000);
        chk("gain_rst2", {14'h0, gain_sel_o}, 16'h0000);
        wb(1'b1, 8'h82);
        for (int i = 0; i < 6; i++) rd(8'h00);
        print_verdict();
    end
endmodule

`default_nettype wire
